//--- design/tsbc_pkg.sv
// Purpose: shared constants and carriers for the test set bus controller
// Assumes: 250 MHz system clock
// Notes: bus timing expressed as least strobe widths in ns
package tsbc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned AD_W = 13;
    localparam int unsigned SEL_W = 4;
    localparam int unsigned MAX_SETS = 16;
    // least strobe width, ns, rounded up to cycles
    localparam int unsigned STROBE_MIN_NS = 1000;
    localparam int unsigned STROBE_CYC =
        (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // least interrupt low time, ns, rounded up to cycles
    localparam int unsigned IRQ_MIN_NS = 10000;
    localparam int unsigned IRQ_CYC_DEF =
        (IRQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // gap between phases so strobes never overlap
    localparam int unsigned GAP_CYC = 2;
    localparam int unsigned CNT_W = 12;
    localparam logic [SEL_W-1:0] SEL_TIED = 4'h0;
    localparam logic [AD_W-1:0] AD_RST = 13'h0000;

    typedef struct packed {
        logic rd;
        logic [AD_W-1:0] addr;
        logic [AD_W-1:0] wdata;
    } tsbc_req_t;

    typedef struct packed {
        logic [AD_W-1:0] o;
        logic oe;
    } tsbc_ad_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_GAP = 3'b010,
        ST_DATA = 3'b011,
        ST_END = 3'b100
    } tsbc_state_t;
endpackage

//--- design/tsbc_top.sv
// Purpose: host end of the rear external test set bus
// Assumes: one clock, async active-low reset, pins synchronised here
// Notes: one bus cycle at a time, address phase then data phase
// Summary of operation
// - thirteen shared lines, three control lines, one open-collector interrupt
// - bus supports up to sixteen chained test sets at once
// - four select outputs held constantly low
// - sweep held off while holdoff input is low
// - address strobe low for at least one microsecond
// - interrupt low ten microseconds aborts sweep; test set holds it
// - data strobe low for at least one microsecond
// - direction line high for read, low for write
// - shared lines carry address then data; read data from test set
`timescale 1ns/100ps
`default_nettype none
module tsbc_top
    import tsbc_pkg::*;
#(
    parameter int unsigned IRQ_CYC = tsbc_pkg::IRQ_CYC_DEF
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire tsbc_pkg::tsbc_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [tsbc_pkg::AD_W-1:0] rsp_rdata,
    input wire logic sweep_req,
    output logic sweep_enable,
    output logic sweep_abort,
    input wire logic [tsbc_pkg::AD_W-1:0] shared_ad_lines_i,
    output logic [tsbc_pkg::AD_W-1:0] shared_ad_lines_o,
    output logic shared_ad_lines_oe,
    output logic addr_strobe_n,
    output logic data_strobe_n,
    output logic read_not_write,
    input wire logic sweep_holdoff_n,
    input wire logic test_irq_n,
    output logic unit_select_bit0,
    output logic [1:0] unit_select_bits_mid,
    output logic unit_select_bit3
);
    import tsbc_pkg::*;

    // two-stage synchronisers for pin inputs
    logic [AD_W-1:0] ad_s1_r, ad_s2_r;
    logic hold_s1_r, hold_s2_r, irq_s1_r, irq_s2_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ad_s1_r <= AD_RST;
            ad_s2_r <= AD_RST;
            hold_s1_r <= 1'b1;
            hold_s2_r <= 1'b1;
            irq_s1_r <= 1'b1;
            irq_s2_r <= 1'b1;
        end else begin
            ad_s1_r <= shared_ad_lines_i;
            ad_s2_r <= ad_s1_r;
            hold_s1_r <= sweep_holdoff_n;
            hold_s2_r <= hold_s1_r;
            irq_s1_r <= test_irq_n;
            irq_s2_r <= irq_s1_r;
        end
    end

    // bus sequencer
    tsbc_state_t st_r, st_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    tsbc_req_t cur_r, cur_nxt;
    logic [AD_W-1:0] ad_o_r, ad_o_nxt, rdata_r, rdata_nxt;
    logic ad_oe_r, ad_oe_nxt, as_n_r, as_n_nxt, ds_n_r, ds_n_nxt;
    logic rnw_r, rnw_nxt, rdy_r, rdy_nxt, rsp_r, rsp_nxt;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        cur_nxt = cur_r;
        ad_o_nxt = ad_o_r;
        ad_oe_nxt = ad_oe_r;
        as_n_nxt = as_n_r;
        ds_n_nxt = ds_n_r;
        rnw_nxt = rnw_r;
        rdy_nxt = rdy_r;
        rsp_nxt = 1'b0;
        rdata_nxt = rdata_r;
        case (st_r)
            ST_IDLE: begin
                if (req_valid && rdy_r) begin
                    cur_nxt = req;
                    rnw_nxt = req.rd;
                    ad_o_nxt = req.addr;
                    ad_oe_nxt = 1'b1;
                    as_n_nxt = 1'b0;
                    cnt_nxt = CNT_W'(STROBE_CYC - 1);
                    rdy_nxt = 1'b0;
                    st_nxt = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (cnt_r == '0) begin
                    as_n_nxt = 1'b1;
                    cnt_nxt = CNT_W'(GAP_CYC - 1);
                    st_nxt = ST_GAP;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_GAP: begin
                if (cnt_r == '0) begin
                    // write drives data, read releases lines
                    ad_o_nxt = cur_r.wdata;
                    ad_oe_nxt = !cur_r.rd;
                    ds_n_nxt = 1'b0;
                    cnt_nxt = CNT_W'(STROBE_CYC - 1);
                    st_nxt = ST_DATA;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_DATA: begin
                if (cnt_r == '0) begin
                    // read data sampled at end of strobe
                    if (cur_r.rd) begin
                        rdata_nxt = ad_s2_r;
                    end
                    ds_n_nxt = 1'b1;
                    st_nxt = ST_END;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            ST_END: begin
                // data held one cycle past strobe release
                ad_oe_nxt = 1'b0;
                rsp_nxt = 1'b1;
                rdy_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
                as_n_nxt = 1'b1;
                ds_n_nxt = 1'b1;
                ad_oe_nxt = 1'b0;
                rdy_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= ST_IDLE;
            cnt_r <= '0;
            cur_r <= '0;
            ad_o_r <= AD_RST;
            ad_oe_r <= 1'b0;
            as_n_r <= 1'b1;
            ds_n_r <= 1'b1;
            rnw_r <= 1'b1;
            rdy_r <= 1'b1;
            rsp_r <= 1'b0;
            rdata_r <= AD_RST;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            cur_r <= cur_nxt;
            ad_o_r <= ad_o_nxt;
            ad_oe_r <= ad_oe_nxt;
            as_n_r <= as_n_nxt;
            ds_n_r <= ds_n_nxt;
            rnw_r <= rnw_nxt;
            rdy_r <= rdy_nxt;
            rsp_r <= rsp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // sweep gating: holdoff stalls, sustained interrupt aborts
    logic [CNT_W+1:0] irq_cnt_r, irq_cnt_nxt;
    logic abort_r, abort_nxt, en_r, en_nxt;

    always_comb begin
        irq_cnt_nxt = irq_cnt_r;
        abort_nxt = 1'b0;
        // low-time qualifier, one abort per low
        if (irq_s2_r) begin
            irq_cnt_nxt = '0;
        end else if (irq_cnt_r < (CNT_W+2)'(IRQ_CYC)) begin
            irq_cnt_nxt = irq_cnt_r + 1'b1;
            abort_nxt = (irq_cnt_r == (CNT_W+2)'(IRQ_CYC - 1));
        end
        en_nxt = sweep_req && hold_s2_r && !abort_nxt;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_cnt_r <= '0;
            abort_r <= 1'b0;
            en_r <= 1'b0;
        end else begin
            irq_cnt_r <= irq_cnt_nxt;
            abort_r <= abort_nxt;
            en_r <= en_nxt;
        end
    end

    logic [SEL_W-1:0] sel_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_r <= SEL_TIED;
        end else begin
            sel_r <= SEL_TIED;
        end
    end

    assign req_ready = rdy_r;
    assign rsp_valid = rsp_r;
    assign rsp_rdata = rdata_r;
    assign sweep_enable = en_r;
    assign sweep_abort = abort_r;
    assign shared_ad_lines_o = ad_o_r;
    assign shared_ad_lines_oe = ad_oe_r;
    assign addr_strobe_n = as_n_r;
    assign data_strobe_n = ds_n_r;
    assign read_not_write = rnw_r;
    assign unit_select_bit0 = sel_r[0];
    assign unit_select_bits_mid = sel_r[2:1];
    assign unit_select_bit3 = sel_r[3];
endmodule // tsbc_top
`default_nettype wire

//--- tb/tsbc_properties.sv
// Purpose: port checks bound into tsbc_top
// Assumes: one clock, async active-low reset
// Notes: phase lengths are the fixed 250/2/250
`timescale 1ns/100ps
`default_nettype none
module tsbc_chk (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic sweep_enable,
    input wire logic sweep_abort,
    input wire logic sweep_holdoff_n,
    input wire logic shared_ad_lines_oe,
    input wire logic addr_strobe_n,
    input wire logic data_strobe_n,
    input wire logic read_not_write
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_no_overlap:
        assert property (addr_strobe_n || data_strobe_n)
            else $error("overlap");
    a_as_width:
        assert property ($fell(addr_strobe_n) |->
            (!addr_strobe_n throughout ##249 1) ##1 addr_strobe_n)
            else $error("as width");
    a_ds_width:
        assert property ($fell(data_strobe_n) |->
            ##250 $rose(data_strobe_n)) else $error("ds width");
    a_phase_gap:
        assert property ($rose(addr_strobe_n) |->
            ##2 $fell(data_strobe_n)) else $error("gap");
    a_rsp_time:
        assert property (req_valid && req_ready |->
            ##[504:504] rsp_valid) else $error("latency");
    a_data_dir:
        assert property ($fell(data_strobe_n) |->
            shared_ad_lines_oe != read_not_write) else $error("dir");
    a_hold_sweep:
        assert property (!sweep_holdoff_n [*5] |-> !sweep_enable)
            else $error("holdoff");
    a_abort_stop:
        assert property (sweep_abort |-> !sweep_enable ##1 !sweep_abort)
            else $error("abort");
    c_read: cover property ($fell(data_strobe_n) && read_not_write);
    c_abort: cover property (sweep_abort);
    c_hold: cover property ($fell(sweep_enable));
endmodule // tsbc_chk
bind tsbc_top tsbc_chk u_chk (.*);
`default_nettype wire

//--- tb/tsbc_test_set.sv
// Purpose: external test set on the shared lines
// Assumes: sixteen word store, low address bits
// Notes: released lines toggle every cycle
`timescale 1ns/100ps
`default_nettype none
module tsbc_test_set (
    input wire logic clk,
    input wire logic [tsbc_pkg::AD_W-1:0] ad_o,
    input wire logic ad_oe,
    input wire logic as_n,
    input wire logic ds_n,
    input wire logic rnw,
    output logic [tsbc_pkg::AD_W-1:0] ad_i
);
    import tsbc_pkg::*;
    logic [AD_W-1:0] mem [16];
    logic [AD_W-1:0] adr;
    logic [AD_W-1:0] last = 13'h0000;
    always @(posedge clk) begin
        if (!as_n) adr <= ad_i;
        if (!ds_n && !rnw) mem[adr[3:0]] <= ad_i;
        last <= ad_i;
    end
    always_comb begin
        if (ad_oe) ad_i = ad_o;
        else if (!ds_n && rnw) ad_i = mem[adr[3:0]];
        else ad_i = ~last;
    end
endmodule // tsbc_test_set
`default_nettype wire

//--- tb/tsbc_top_tb.sv
// Purpose: self-checking bench for tsbc_top
// Assumes: 4 ns clock, interrupt count cut to 8
// Notes: one test set model on the shared lines
`timescale 1ns/100ps
`default_nettype none
module tsbc_top_tb;
    import tsbc_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic req_valid = 1'b0;
    tsbc_req_t req = '0;
    logic sweep_req = 1'b0;
    logic sweep_holdoff_n = 1'b1;
    logic test_irq_n = 1'b1;
    logic req_ready, rsp_valid, sweep_enable, sweep_abort;
    logic shared_ad_lines_oe, addr_strobe_n, data_strobe_n, read_not_write;
    logic unit_select_bit0, unit_select_bit3;
    logic [1:0] unit_select_bits_mid;
    logic [AD_W-1:0] rsp_rdata, shared_ad_lines_i, shared_ad_lines_o;
    int errors = 0;
    int tests_run = 0;
    int aborts = 0;
    tsbc_top #(.IRQ_CYC(8)) u_dut (.clk(clk), .arst_n(arst_n),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .sweep_req(sweep_req), .sweep_enable(sweep_enable),
        .sweep_abort(sweep_abort), .shared_ad_lines_i(shared_ad_lines_i),
        .shared_ad_lines_o(shared_ad_lines_o),
        .shared_ad_lines_oe(shared_ad_lines_oe),
        .addr_strobe_n(addr_strobe_n), .data_strobe_n(data_strobe_n),
        .read_not_write(read_not_write), .sweep_holdoff_n(sweep_holdoff_n),
        .test_irq_n(test_irq_n), .unit_select_bit0(unit_select_bit0),
        .unit_select_bits_mid(unit_select_bits_mid),
        .unit_select_bit3(unit_select_bit3));
    tsbc_test_set u_ts (.clk(clk), .ad_o(shared_ad_lines_o),
        .ad_oe(shared_ad_lines_oe), .as_n(addr_strobe_n),
        .ds_n(data_strobe_n), .rnw(read_not_write), .ad_i(shared_ad_lines_i));
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (sweep_abort === 1'b1) aborts++;
    task automatic chk(input logic [AD_W-1:0] got, input logic [AD_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // one whole bus cycle; ready is high whenever this is entered
    task automatic bus(input logic rd, input logic [AD_W-1:0] a,
            input logic [AD_W-1:0] d);
        int n;
        logic seen;
        logic oe_seen;
        n = 0;
        seen = 1'bx;
        oe_seen = 1'bx;
        req = '{rd: rd, addr: a, wdata: d};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        chk(13'(req_ready), 13'h0000);
        while (rsp_valid !== 1'b1) begin
            if (data_strobe_n === 1'b0) begin
                seen = read_not_write;
                oe_seen = shared_ad_lines_oe;
            end
            if (++n > 600) begin
                errors++;
                tally_and_finish();
            end
            @(negedge clk);
        end
        chk(13'(seen), 13'(rd));
        chk(13'(oe_seen), 13'(!rd));
        chk(13'(req_ready), 13'h0001);
    endtask
    task automatic t_reset();
        chk(13'({unit_select_bit3, unit_select_bits_mid, unit_select_bit0}),
            13'h0000);
        chk(13'({addr_strobe_n, data_strobe_n}), 13'h0003);
        chk(13'({read_not_write, req_ready}), 13'h0003);
        $display("done reset");
    endtask
    task automatic t_write_read();
        bus(1'b0, 13'h0005, 13'h1abc);
        bus(1'b0, 13'h1fff, 13'h0555);
        bus(1'b1, 13'h0005, 13'h0000);
        chk(rsp_rdata, 13'h1abc);
        bus(1'b1, 13'h1fff, 13'h0000);
        chk(rsp_rdata, 13'h0555);
        $display("done write_read");
    endtask
    // reset dropped inside an address phase returns the bus to idle
    task automatic t_mid_reset();
        req = '{rd: 1'b0, addr: 13'h0003, wdata: 13'h0123};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        repeat (20) @(negedge clk);
        chk(13'(addr_strobe_n), 13'h0000);
        arst_n = 1'b0;
        @(negedge clk);
        chk(13'({addr_strobe_n, data_strobe_n}), 13'h0003);
        chk(13'({shared_ad_lines_oe, req_ready}), 13'h0001);
        repeat (2) @(negedge clk);
        arst_n = 1'b1;
        bus(1'b1, 13'h0005, 13'h0000);
        chk(rsp_rdata, 13'h1abc);
        $display("done mid_reset");
    endtask
    task automatic t_holdoff();
        sweep_req = 1'b1;
        repeat (6) @(negedge clk);
        chk(13'(sweep_enable), 13'h0001);
        sweep_holdoff_n = 1'b0;
        repeat (6) @(negedge clk);
        chk(13'(sweep_enable), 13'h0000);
        sweep_holdoff_n = 1'b1;
        repeat (6) @(negedge clk);
        chk(13'(sweep_enable), 13'h0001);
        $display("done holdoff");
    endtask
    // a short low must not abort, a long one aborts once
    task automatic t_irq();
        aborts = 0;
        test_irq_n = 1'b0;
        repeat (6) @(negedge clk);
        test_irq_n = 1'b1;
        repeat (12) @(negedge clk);
        chk(13'(aborts), 13'h0000);
        test_irq_n = 1'b0;
        repeat (30) @(negedge clk);
        test_irq_n = 1'b1;
        repeat (12) @(negedge clk);
        chk(13'(aborts), 13'h0001);
        chk(13'(sweep_enable), 13'h0001);
        $display("done irq");
    endtask
    initial begin
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        t_reset();
        t_write_read();
        t_mid_reset();
        t_holdoff();
        t_irq();
        tally_and_finish();
    end
endmodule // tsbc_top_tb
`default_nettype wire
